// >>> core/dpmx_regs.svh
`ifndef DPMX_REGS_SVH
`define DPMX_REGS_SVH
// pulse timer: 10 ms step per duration code, 100 MHz clock
`define DPMX_CLK_HZ 100000000
`define DPMX_PULSE_STEP_MS 10
`define DPMX_PULSE_STEP_CYC ((`DPMX_CLK_HZ / 1000) * `DPMX_PULSE_STEP_MS)
`define DPMX_DUR_OFF 3'h0
`define DPMX_DUR_HOLD 3'h7
// reset values of control fields
`define DPMX_MODE_RST 3'h0
`define DPMX_TXDIS_RST 1'h0
`endif

// >>> core/dpmx_pkg.sv
package dpmx_pkg;
  // signaling mode selector
  typedef enum logic [2:0] {
    DPMX_MODE_USB = 3'h0,
    DPMX_MODE_UART1 = 3'h1,
    DPMX_MODE_UART2 = 3'h2,
    DPMX_MODE_RSVD = 3'h3,
    DPMX_MODE_MONO = 3'h4,
    DPMX_MODE_STEREO = 3'h5,
    DPMX_MODE_LOOP_R = 3'h6,
    DPMX_MODE_LOOP_L = 3'h7
  } dpmx_mode_t;
  // regulator state
  typedef enum logic [1:0] {
    DPMX_REG_OFF,
    DPMX_REG_LOW,
    DPMX_REG_FULL
  } dpmx_reg_t;
endpackage

// >>> core/dpmx_if.sv
`timescale 1ns/1ns
// digital pins between the host-side controller and the transceiver
interface dpmx_if;
  logic transmit_enable_n;
  logic dat_host_o;
  logic dat_host_oe;
  logic dat_dev_o;
  logic dat_dev_oe;
  logic se_host_o;
  logic se_host_oe;
  logic se_dev_o;
  logic se_dev_oe;
  logic differential_receive_out;
  logic plus_receive_out;
  logic minus_receive_out;
  // resolved levels, pull-low when nobody drives
  wire data_plus_pin = dat_dev_oe ? dat_dev_o :
    (dat_host_oe ? dat_host_o : 1'b0);
  wire single_ended_minus_pin = se_dev_oe ? se_dev_o :
    (se_host_oe ? se_host_o : 1'b0);
  modport dev (
    input transmit_enable_n, dat_host_o, dat_host_oe, se_host_o,
    se_host_oe, data_plus_pin, single_ended_minus_pin,
    output dat_dev_o, dat_dev_oe, se_dev_o, se_dev_oe,
    differential_receive_out, plus_receive_out, minus_receive_out
  );
  modport host (
    output transmit_enable_n, dat_host_o, dat_host_oe, se_host_o,
    se_host_oe,
    input dat_dev_o, dat_dev_oe, se_dev_o, se_dev_oe,
    differential_receive_out, plus_receive_out, minus_receive_out,
    data_plus_pin, single_ended_minus_pin
  );
endinterface

// >>> core/dpmx_fifo.sv
`timescale 1ns/1ns
// small flip-flop fifo with valid/ready on both sides
module dpmx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i, // clock
  input wire logic srst_i, // sync reset
  input wire logic [WIDTH-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write valid
  output logic in_ready_o, // not full
  output logic [WIDTH-1:0] out_data_o, // read data
  output logic out_valid_o, // not empty
  input wire logic out_ready_i // read ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rd_r];
  // storage written only on push
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end
  // pointers wrap on depth
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> core/dpmx_device.sv
`timescale 1ns/1ns
`include "dpmx_regs.svh"
// Overview of operation
// - nonzero duration gives low-current regulator on
// - expiry clears duration field, regulator off
// - code 111 holds low current indefinitely
// - full enable overrides, regulator at 100 mA
// - codes 001..110 give 10..60 ms
// - mode 000 transceiver, uart/audio hi-z
// - mode 001 uart tx minus, rx plus
// - mode 010 uart tx plus, rx minus-receive
// - modes 100/101 mono or stereo audio
// - data modes keep audio off the lines
// - modes 110/111 usb plus audio loopback
// - transmit-disable bit tristates uart tx
// - speed select picks low or full
// - host picks speed from line pull
// - transceiver enable needs reset_n, pin/bit
// - two bits select interface wiring style
// - plus/minus bidirectional transmit and receive
// - plus/minus unidirectional receive on dedicated pins
// - data/se0 transmit, single-ended pin high forces both low
// - data/se0 bidirectional receive, se0 decode
// - data/se0 unidirectional receive on dedicated pins
module dpmx_device
  import dpmx_pkg::*;
#(
  parameter int unsigned STEP_CYC = `DPMX_PULSE_STEP_CYC
) (
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic srst_i, // sync reset, active high
  dpmx_if.dev pins, // digital pins toward host
  input wire logic full_regulator_enable_i, // full regulator enable
  input wire logic [2:0] dur_wdata_i, // duration write value
  input wire logic dur_we_i, // duration write strobe
  output logic [2:0] vbus_pulse_duration_o, // duration readback
  output logic reg_on_o, // vbus regulator on
  output logic reg_low_limit_o, // 910 ua limit selected
  input wire logic [2:0] mode_i, // signaling mode field
  input wire logic serial_swap_i, // uart line swap
  input wire logic serial_tx_disable_i, // uart tx tristate
  input wire logic speed_select_i, // 1 full speed
  input wire logic pin_control_allow_i, // enable pin allowed
  input wire logic enable_pin_i, // transceiver enable pin
  input wire logic transceiver_enable_bit_i, // enable bit
  input wire logic reset_n_i, // device reset, low active
  input wire logic single_ended_encoding_sel_i, // 1 data/se0
  input wire logic pin_direction_sel_i, // 1 bidirectional
  input wire logic cable_plus_i, // cable plus line level
  input wire logic cable_minus_i, // cable minus line level
  output logic cable_plus_o, // cable plus drive value
  output logic cable_plus_oe_o, // cable plus drive enable
  output logic cable_minus_o, // cable minus drive value
  output logic cable_minus_oe_o, // cable minus drive enable
  output logic xcvr_on_o, // transceiver enabled
  output logic full_speed_o, // full speed active
  input wire logic speaker_left_i, // left speaker audio
  input wire logic speaker_right_i, // right speaker audio
  output logic voice_input_line_o, // microphone path
  output logic audio_plus_on_o, // audio switch on plus
  output logic audio_minus_on_o, // audio switch on minus
  output logic spk_left_o, // loopback left speaker
  output logic spk_right_o // loopback right speaker
);
  logic [2:0] dur_r;
  logic [2:0] dur_nxt;
  logic [2:0] steps_r;
  logic [31:0] cyc_r;
  logic [2:0] dp_s_r;
  logic [2:0] dm_s_r;
  dpmx_reg_t reg_st;
  dpmx_mode_t mode;
  assign mode = dpmx_mode_t'(mode_i);

  // pulse timer: counts 10 ms steps until the coded count
  wire timed = dur_r != `DPMX_DUR_OFF && dur_r != `DPMX_DUR_HOLD;
  wire step_done = cyc_r == STEP_CYC - 1;
  wire expire = !full_regulator_enable_i && timed && step_done &&
    steps_r == dur_r - 3'h1;
  always_comb begin
    dur_nxt = dur_r;
    if (dur_we_i) begin
      dur_nxt = dur_wdata_i;
    end else if (expire) begin
      dur_nxt = `DPMX_DUR_OFF;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dur_r <= `DPMX_DUR_OFF;
      cyc_r <= '0;
      steps_r <= '0;
    end else begin
      dur_r <= dur_nxt;
      if (dur_we_i || !timed || full_regulator_enable_i) begin
        cyc_r <= '0;
        steps_r <= '0;
      end else if (step_done) begin
        cyc_r <= '0;
        steps_r <= steps_r + 3'h1;
      end else begin
        cyc_r <= cyc_r + 32'h1;
      end
    end
  end
  assign reg_st = full_regulator_enable_i ? DPMX_REG_FULL :
    (dur_r != `DPMX_DUR_OFF ? DPMX_REG_LOW : DPMX_REG_OFF);
  assign reg_on_o = reg_st != DPMX_REG_OFF;
  assign reg_low_limit_o = reg_st == DPMX_REG_LOW;
  assign vbus_pulse_duration_o = dur_r;

  // cable lines: three stages, change accepted when 2nd/3rd agree
  logic dp_q_r;
  logic dm_q_r;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dp_s_r <= '0;
      dm_s_r <= '0;
      dp_q_r <= 1'b0;
      dm_q_r <= 1'b0;
    end else begin
      dp_s_r <= {dp_s_r[1:0], cable_plus_i};
      dm_s_r <= {dm_s_r[1:0], cable_minus_i};
      if (dp_s_r[1] == dp_s_r[2]) dp_q_r <= dp_s_r[2];
      if (dm_s_r[1] == dm_s_r[2]) dm_q_r <= dm_s_r[2];
    end
  end

  wire usb_mode = mode == DPMX_MODE_USB || mode == DPMX_MODE_LOOP_R ||
    mode == DPMX_MODE_LOOP_L;
  assign xcvr_on_o = reset_n_i && usb_mode &&
    ((enable_pin_i && pin_control_allow_i) || transceiver_enable_bit_i);
  assign full_speed_o = speed_select_i;

  wire uart1 = mode == DPMX_MODE_UART1;
  wire uart2 = mode == DPMX_MODE_UART2;
  wire uart_m = uart1 || uart2;
  wire tx_n = pins.transmit_enable_n;
  wire dse = single_ended_encoding_sel_i;
  wire bidir = pin_direction_sel_i;
  wire xmit = xcvr_on_o && !tx_n;
  wire recv = xcvr_on_o && tx_n;
  wire fse0 = dse && pins.single_ended_minus_pin;
  wire usb_p = dse ? (pins.data_plus_pin && !fse0) : pins.data_plus_pin;
  wire usb_m = dse ? (!pins.data_plus_pin && !fse0) :
    pins.single_ended_minus_pin;
  wire uart_tx = uart1 ? pins.single_ended_minus_pin : pins.data_plus_pin;
  wire uart_drv = uart_m && !serial_tx_disable_i;
  wire rx_line = serial_swap_i ? dm_q_r : dp_q_r;
  wire diff_rx = dp_q_r && !dm_q_r;
  wire se0_rx = !dp_q_r && !dm_q_r;

  // cable drive, one source at a time
  always_comb begin
    cable_plus_o = 1'b0;
    cable_minus_o = 1'b0;
    cable_plus_oe_o = 1'b0;
    cable_minus_oe_o = 1'b0;
    if (xmit) begin
      cable_plus_o = usb_p;
      cable_minus_o = usb_m;
      cable_plus_oe_o = 1'b1;
      cable_minus_oe_o = 1'b1;
    end else if (uart_drv) begin
      cable_plus_o = uart_tx;
      cable_minus_o = uart_tx;
      cable_plus_oe_o = serial_swap_i;
      cable_minus_oe_o = !serial_swap_i;
    end
  end

  always_comb begin
    pins.dat_dev_o = 1'b0;
    pins.dat_dev_oe = 1'b0;
    pins.se_dev_o = 1'b0;
    pins.se_dev_oe = 1'b0;
    pins.differential_receive_out = 1'b0;
    pins.plus_receive_out = dp_q_r;
    pins.minus_receive_out = dm_q_r;
    if (recv) begin
      pins.differential_receive_out = diff_rx;
      if (bidir && !dse) begin
        pins.dat_dev_o = dp_q_r;
        pins.se_dev_o = dm_q_r;
        pins.dat_dev_oe = 1'b1;
        pins.se_dev_oe = 1'b1;
      end else if (bidir && dse) begin
        pins.dat_dev_o = diff_rx;
        pins.se_dev_o = se0_rx;
        pins.dat_dev_oe = 1'b1;
        pins.se_dev_oe = 1'b1;
      end
    end else if (uart1) begin
      pins.dat_dev_o = rx_line;
      pins.dat_dev_oe = 1'b1;
    end else if (uart2) begin
      pins.minus_receive_out = rx_line;
    end
  end

  assign audio_minus_on_o = mode == DPMX_MODE_MONO ||
    mode == DPMX_MODE_STEREO;
  assign audio_plus_on_o = audio_minus_on_o;
  assign voice_input_line_o = mode == DPMX_MODE_MONO ? dp_q_r : 1'b0;
  assign spk_left_o = mode == DPMX_MODE_LOOP_L ? dp_q_r : speaker_left_i;
  assign spk_right_o = mode == DPMX_MODE_LOOP_R ? dp_q_r :
    speaker_right_i;
endmodule

// >>> core/dpmx_host.sv
`timescale 1ns/1ns
`include "dpmx_regs.svh"
// host-side controller: sends fifo words as {dat, se} pairs on the data and single-ended pins
module dpmx_host
  import dpmx_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic srst_i, // sync reset, active high
  dpmx_if.host pins, // digital pins toward device
  input wire logic single_ended_encoding_sel_i, // 1 data/se0
  input wire logic pin_direction_sel_i, // 1 bidirectional
  input wire logic [1:0] tx_data_i, // {dat, se} symbol
  input wire logic tx_valid_i, // symbol valid
  output logic tx_ready_o, // fifo accepts
  input wire logic tx_hold_i, // stall draining
  output logic rx_diff_o, // sampled receive data
  output logic rx_plus_o, // sampled plus
  output logic rx_minus_o, // sampled minus
  output logic speed_select_o // detected full speed
);
  logic [1:0] q_data;
  logic q_valid;
  logic [1:0] sym_r;
  logic send_r;
  logic [2:0] rp_r;
  logic [2:0] rm_r;
  logic [2:0] rd_r;
  wire pop = q_valid && !tx_hold_i;
  // queue absorbs bursts; tx_hold stalls drain and fills it
  dpmx_fifo #(.WIDTH(2), .DEPTH(DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(q_data),
    .out_valid_o(q_valid),
    .out_ready_i(!tx_hold_i)
  );
  // one symbol per cycle onto the pins
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sym_r <= 2'h0;
      send_r <= 1'b0;
    end else begin
      send_r <= pop;
      if (pop) sym_r <= q_data;
    end
  end
  assign pins.transmit_enable_n = !send_r;
  assign pins.dat_host_o = sym_r[1];
  assign pins.se_host_o = sym_r[0];
  assign pins.dat_host_oe = send_r;
  assign pins.se_host_oe = send_r;
  // three-stage sampling of device outputs
  wire dp_src = pin_direction_sel_i && !single_ended_encoding_sel_i ?
    pins.data_plus_pin : pins.plus_receive_out;
  wire dm_src = pin_direction_sel_i && !single_ended_encoding_sel_i ?
    pins.single_ended_minus_pin : pins.minus_receive_out;
  wire dr_src = pin_direction_sel_i && single_ended_encoding_sel_i ?
    pins.data_plus_pin : pins.differential_receive_out;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rp_r <= '0;
      rm_r <= '0;
      rd_r <= '0;
      rx_plus_o <= 1'b0;
      rx_minus_o <= 1'b0;
      rx_diff_o <= 1'b0;
      speed_select_o <= 1'b0;
    end else begin
      rp_r <= {rp_r[1:0], dp_src};
      rm_r <= {rm_r[1:0], dm_src};
      rd_r <= {rd_r[1:0], dr_src};
      if (rp_r[1] == rp_r[2]) rx_plus_o <= rp_r[2];
      if (rm_r[1] == rm_r[2]) rx_minus_o <= rm_r[2];
      if (rd_r[1] == rd_r[2]) rx_diff_o <= rd_r[2];
      if (!send_r && rx_plus_o != rx_minus_o) speed_select_o <= rx_plus_o;
    end
  end
endmodule

// >>> bench/dpmx_props.sv
`timescale 1ns/1ns
// checks on the pin interface and device outputs
module dpmx_props #(
  parameter int unsigned STEP_CYC = 10
) (
  input wire logic sys_clk_i, // clock
  input wire logic srst_i, // sync reset
  input wire logic transmit_enable_n, // low: transmit
  input wire logic single_ended_minus_pin, // resolved pin
  input wire logic full_regulator_enable_i, // full enable
  input wire logic dur_we_i, // duration write
  input wire logic [2:0] vbus_pulse_duration_o, // duration
  input wire logic reg_on_o, // regulator on
  input wire logic reg_low_limit_o, // low limit
  input wire logic [2:0] mode_i, // mode field
  input wire logic serial_swap_i, // uart swap
  input wire logic serial_tx_disable_i, // uart tx off
  input wire logic single_ended_encoding_sel_i, // data/se0
  input wire logic xcvr_on_o, // transceiver on
  input wire logic cable_plus_o, // plus value
  input wire logic cable_plus_oe_o, // plus enable
  input wire logic cable_minus_o, // minus value
  input wire logic cable_minus_oe_o, // minus enable
  input wire logic audio_plus_on_o, // audio on plus
  input wire logic audio_minus_on_o // audio on minus
);
  logic [31:0] age_r;
  logic [31:0] age_nxt;
  // pulse age; codes 0 and 7 never expire, so they do not count
  assign age_nxt = (dur_we_i || vbus_pulse_duration_o == 3'h0 ||
    vbus_pulse_duration_o == 3'h7) ? 32'h0 : age_r + 32'h1;
  always_ff @(posedge sys_clk_i) begin
    age_r <= srst_i ? 32'h0 : age_nxt;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  // a live timed pulse, then its field cleared
  sequence s_timed;
    !full_regulator_enable_i && !dur_we_i &&
    vbus_pulse_duration_o inside {[3'h1:3'h6]};
  endsequence
  sequence s_expired;
    vbus_pulse_duration_o == 3'h0;
  endsequence
  a_pulse_len: assert property (s_timed ##1 s_expired |->
    $past(age_r) + 32'h1 == $past(vbus_pulse_duration_o) * STEP_CYC)
    else $error("timed pulse length wrong");
  a_low_limit_on: assert property (!full_regulator_enable_i &&
    vbus_pulse_duration_o != 3'h0 |-> reg_on_o && reg_low_limit_o)
    else $error("low current regulator not on");
  a_hold_code: assert property (vbus_pulse_duration_o == 3'h7 &&
    !dur_we_i |=> vbus_pulse_duration_o == 3'h7)
    else $error("hold code lost");
  a_full_override: assert property (full_regulator_enable_i |->
    reg_on_o && !reg_low_limit_o) else $error("full enable ignored");
  a_reserved_off: assert property (mode_i == 3'h3 |-> !xcvr_on_o &&
    !cable_plus_oe_o && !cable_minus_oe_o && !audio_plus_on_o &&
    !audio_minus_on_o) else $error("reserved mode active");
  a_data_no_audio: assert property (mode_i inside {3'h0, 3'h1,
    3'h2, 3'h6, 3'h7} |-> !audio_plus_on_o && !audio_minus_on_o)
    else $error("audio on data lines");
  a_se0_forces_low: assert property (!transmit_enable_n &&
    xcvr_on_o && single_ended_encoding_sel_i && single_ended_minus_pin |->
    cable_plus_oe_o && cable_minus_oe_o && !cable_plus_o && !cable_minus_o)
    else $error("se0 not forced");
  a_uart_tx_route: assert property (mode_i == 3'h1 &&
    !serial_swap_i |-> !cable_plus_oe_o &&
    cable_minus_oe_o == !serial_tx_disable_i &&
    (serial_tx_disable_i || cable_minus_o == single_ended_minus_pin))
    else $error("uart tx routing wrong");
endmodule

// >>> bench/dpmx_tb_top.sv
`timescale 1ns/1ns
module dpmx_tb_top;
  import dpmx_pkg::*;
  localparam int STEP = 10;
  logic clk = 1'h0, rst = 1'h1, full = 1'h0, we = 1'h0, swap = 1'h0;
  logic txdis = 1'h0, pok = 1'h0, epin = 1'h0, xbit = 1'h1, rstn = 1'h1;
  logic enc = 1'h0, bidir = 1'h0, cp = 1'h1, cm = 1'h0, txv = 1'h0;
  logic hold = 1'h0, spk = 1'h0;
  logic [2:0] dw = 3'h0, mode = 3'h0, dur;
  logic [1:0] txd = 2'h0;
  logic ron, rlow, cpo, cpoe, cmo, cmoe, xon, fs, ap, am, ll, lr, txr, spd;
  logic voice_input_line, rxd, rxp, rxm;
  // cable level: device drive wins over the far end
  wire logic cpi = cpoe ? cpo : cp;
  wire logic cmi = cmoe ? cmo : cm;
  int err_total = 0, checked = 0;
  dpmx_if bus();
  dpmx_device #(.STEP_CYC(STEP)) u_dpmx_device (
    .sys_clk_i(clk), .srst_i(rst), .pins(bus),
    .full_regulator_enable_i(full), .dur_wdata_i(dw), .dur_we_i(we),
    .vbus_pulse_duration_o(dur), .reg_on_o(ron), .reg_low_limit_o(rlow),
    .mode_i(mode), .serial_swap_i(swap), .serial_tx_disable_i(txdis),
    .speed_select_i(spd), .pin_control_allow_i(pok), .enable_pin_i(epin),
    .transceiver_enable_bit_i(xbit), .reset_n_i(rstn),
    .single_ended_encoding_sel_i(enc), .pin_direction_sel_i(bidir),
    .cable_plus_i(cpi), .cable_minus_i(cmi), .cable_plus_o(cpo),
    .cable_plus_oe_o(cpoe), .cable_minus_o(cmo), .cable_minus_oe_o(cmoe),
    .xcvr_on_o(xon), .full_speed_o(fs), .speaker_left_i(spk),
    .speaker_right_i(spk), .voice_input_line_o(voice_input_line), .audio_plus_on_o(ap),
    .audio_minus_on_o(am), .spk_left_o(ll), .spk_right_o(lr));
  dpmx_host u_dpmx_host (
    .sys_clk_i(clk), .srst_i(rst), .pins(bus),
    .single_ended_encoding_sel_i(enc), .pin_direction_sel_i(bidir),
    .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr), .tx_hold_i(hold),
    .rx_diff_o(rxd), .rx_plus_o(rxp), .rx_minus_o(rxm), .speed_select_o(spd));
  dpmx_props #(.STEP_CYC(STEP)) u_dpmx_props (
    .sys_clk_i(clk), .srst_i(rst),
    .transmit_enable_n(bus.transmit_enable_n),
    .single_ended_minus_pin(bus.single_ended_minus_pin),
    .full_regulator_enable_i(full), .dur_we_i(we),
    .vbus_pulse_duration_o(dur), .reg_on_o(ron), .reg_low_limit_o(rlow),
    .mode_i(mode), .serial_swap_i(swap), .serial_tx_disable_i(txdis),
    .single_ended_encoding_sel_i(enc), .xcvr_on_o(xon),
    .cable_plus_o(cpo), .cable_plus_oe_o(cpoe), .cable_minus_o(cmo),
    .cable_minus_oe_o(cmoe), .audio_plus_on_o(ap), .audio_minus_on_o(am));
  // compare and count
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // inputs move only on falling edges
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic hang;
    err_total++;
    print_verdict();
  endtask
  task automatic wdur(logic [2:0] v);
    dw = v;
    we = 1'h1;
    cyc(1);
    we = 1'h0;
  endtask
  task automatic t_pulse;
    int n;
    for (int c = 1; c < 7; c++) begin
      wdur(3'(c));
      chk("low", 8'h1, 8'(ron & rlow));
      for (n = 0; dur !== 3'h0; n++) begin
        if (n > 99) hang();
        cyc(1);
      end
      chk("len", 8'(c * STEP), 8'(n));
      chk("off", 8'h0, 8'(ron));
    end
    wdur(3'h7);
    cyc(99);
    chk("hold", 8'h7, 8'(dur));
    full = 1'h1;
    cyc(1);
    chk("full", 8'h1, 8'(ron & ~rlow));
    full = 1'h0;
    wdur(3'h0);
    chk("zero", 8'h0, 8'(ron));
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      mode = 3'(m);
      // plus level opposite the speaker input, so a loop is visible
      cp = m[0] ^ m[2];
      cm = ~cp;
      spk = ~cp;
      cyc(8);
      chk("mic", 8'(m == 4), 8'(voice_input_line));
      chk("xcvr", 8'(m == 0 || m > 5), 8'(xon));
      chk("drv", 8'(m == 1 || m == 2), 8'(cpoe | cmoe));
      chk("audio", 8'(m == 4 || m == 5), 8'(am));
      if (m > 5) chk("loop", 8'(cp), 8'(m == 6 ? lr : ll));
    end
  endtask
  task automatic t_uart;
    for (int k = 0; k < 4; k++) begin
      mode = k[1] ? 3'h2 : 3'h1;
      swap = k[0];
      cp = ~k[0];
      cm = k[0];
      cyc(8);
      chk("tx_oe", k[0] ? 8'h2 : 8'h1, 8'({cpoe, cmoe}));
      chk("rx", 8'h1, k[1] ? 8'(bus.minus_receive_out) :
        8'(bus.data_plus_pin));
      txdis = 1'h1;
      cyc(1);
      chk("tx_off", 8'h0, 8'({cpoe, cmoe}));
      txdis = 1'h0;
    end
  endtask
  // pin path alone, then reset gating, then the enable bit alone
  task automatic t_enable;
    mode = 3'h0;
    xbit = 1'h0;
    pok = 1'h1;
    epin = 1'h1;
    cyc(2);
    chk("pin_en", 8'h1, 8'(xon));
    rstn = 1'h0;
    cyc(2);
    chk("rst_off", 8'h0, 8'(xon));
    rstn = 1'h1;
    pok = 1'h0;
    cyc(2);
    chk("bit_off", 8'h0, 8'(xon));
    xbit = 1'h1;
    cyc(1);
    chk("bit_on", 8'h1, 8'(xon));
  endtask
  // fill the host buffer while stalled, then drain onto the cable
  task automatic t_tx(logic e);
    logic [1:0] q[$];
    logic [1:0] s;
    int n;
    enc = e;
    hold = 1'h1;
    for (n = 0; n < 20 && txr === 1'h1; n++) begin
      s = (n % 3 == 2) ? 2'h0 : (n[0] ? 2'h2 : 2'h1);
      txd = s;
      txv = 1'h1;
      q.push_back(e ? (s[0] ? 2'h0 : {s[1], ~s[1]}) : s);
      cyc(1);
    end
    txv = 1'h0;
    chk("fill", 8'h10, 8'(n));
    hold = 1'h0;
    for (int k = 0; k < 99 && q.size() > 0; k++) begin
      cyc(1);
      if (bus.transmit_enable_n === 1'h0)
        chk("sym", 8'(q.pop_front()), 8'({cpo, cmo}));
    end
    if (q.size() > 0) hang();
  endtask
  task automatic t_rx;
    cp = 1'h1;
    cm = 1'h0;
    for (int k = 0; k < 4; k++) begin
      enc = k[1];
      bidir = k[0];
      cyc(8);
      chk("rcv", 8'h1, k == 3 ? 8'(bus.data_plus_pin) :
        8'(bus.differential_receive_out));
      chk("pm", 8'h2, k[0] ?
        8'({bus.data_plus_pin, bus.single_ended_minus_pin}) :
        8'({bus.plus_receive_out, bus.minus_receive_out}));
    end
    cp = 1'h0;
    cyc(8);
    chk("se0", 8'h1, 8'(bus.single_ended_minus_pin));
    enc = 1'h0;
    bidir = 1'h0;
    for (int k = 0; k < 2; k++) begin
      cp = ~k[0];
      cm = k[0];
      cyc(20);
      chk("speed", k ? 8'h0 : 8'h3, 8'({spd, fs}));
      chk("host_rx", k ? 8'h1 : 8'h6, 8'({rxd, rxp, rxm}));
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    cyc(20);
    rst = 1'h0;
    t_pulse();
    t_modes();
    t_uart();
    t_enable();
    t_tx(1'h0);
    t_tx(1'h1);
    t_rx();
    print_verdict();
  end
endmodule
